// *** strap_pkg.sv ***
// package for the reset strap capture block: register map, field layout, timing
// assumes a 32-bit apb register bus at 10 mhz and one platform clock
package strap_pkg;
	localparam int unsigned CLK_HZ = 10_000_000; // platform clock rate
	localparam int unsigned PULLUP_HOLD_NS = 500; // pull-up stays on after release
	localparam int unsigned PULLUP_HOLD_CYC =
		(PULLUP_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // rounds up
	localparam int unsigned NUM_CFG = 8; // number of strap pins
	localparam int unsigned NUM_LANES = 8; // serial lanes
	localparam int unsigned NUM_PLL = 4; // pll ratio strap pins, no pull-up
	// register byte addresses
	localparam logic [19:0] SERIAL_LANE_CONTROL_1_OFF = 20'he0f08;
	localparam logic [19:0] DEVICE_DISABLE_OFF = 20'he0070;
	localparam logic [19:0] STRAP_STATUS_OFF = 20'he0f80;
	// strap bit positions in the captured word
	localparam int unsigned SRDS_EN_BIT = 0; // serial block enable strap
	localparam int unsigned PCI_ARB_BIT = 1; // pci arbiter enable strap
	// field positions
	localparam int unsigned LANE_PD_LSB = 0; // lane power-down field
	localparam int unsigned DIS_PCI_BIT = 0; // device disable: pci block
	localparam int unsigned SRDS_PD_BIT = 8; // status: serial block powered down
	localparam int unsigned CAP_DONE_BIT = 9; // status: capture done
	localparam int unsigned PLL_LSB = 16; // status: pll straps
	localparam logic [31:0] LANE_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DEV_DIS_RST = 32'h0000_0000;
	// settings decoded from the straps
	typedef struct packed {
		logic srds_block_pd; // whole serial block down
		logic pci_arb_en; // arbiter enabled
	} strap_cfg_t;
	// apb request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [19:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage

// *** reset_strap_capture.sv ***
// reset strap capture: samples configuration straps under hard reset, latches them on
// release, runs gated pull-ups, and applies lane, pci and serial block settings.
// assumes hard_reset_n_i and pins are synchronous to clk_i; apb bus on the same clock.
// the pll ratio straps are captured like the others but get no pull-up control,
// so a board that leaves them open reads whatever the pads float to.
module reset_strap_capture
	import strap_pkg::*;
#(
	parameter bit EARLY_REV = 1'b1 // earlier silicon revision behaviour
)(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hard_reset_n_i,
	input wire logic soft_reset_n_i,
	input wire logic [strap_pkg::NUM_CFG-1:0] cfg_pin_i,
	input wire logic [strap_pkg::NUM_CFG-1:0] func_out_i,
	input wire logic [strap_pkg::NUM_PLL-1:0] pll_pin_i,
	input wire logic [strap_pkg::NUM_LANES-1:0] serial_lane_rx_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [19:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [strap_pkg::NUM_CFG-1:0] cfg_pin_o,
	output logic [strap_pkg::NUM_CFG-1:0] cfg_pin_oe_o,
	output logic [strap_pkg::NUM_CFG-1:0] cfg_rx_en_o,
	output logic [strap_pkg::NUM_CFG-1:0] cfg_pullup_en_o,
	output logic [strap_pkg::NUM_LANES-1:0] serial_lane_rx_o,
	output logic serial_block_pd_o,
	output logic pci_ad_oe_o,
	output logic pci_block_en_o,
	output logic machine_check_o
);
	// reset synchroniser: first stage feeds only the second
	// the async assert reaches every flop at once; release is retimed so that
	// no flop leaves reset a cycle ahead of its neighbours
	logic rst_s1_q;
	logic rst_n;
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// the bus inputs are bundled once so that the decode below reads one carrier
	// rather than five loose ports
	apb_req_t req; // bundled bus request
	assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
		paddr: paddr_i, pwdata: pwdata_i};

	// capture state: the previous hard reset level gives a one-cycle release strobe,
	// and the hold counter keeps the pull-ups on a little past the release
	logic hr_prev_q; // last cycle's hard reset level
	logic [NUM_CFG-1:0] cap_q; // captured straps
	logic [NUM_PLL-1:0] pll_q; // captured pll ratio straps
	logic done_q; // capture done, pins in functional role
	logic [7:0] hold_q; // pull-up hold countdown
	logic release_w; // hard reset deasserting this cycle
	assign release_w = hard_reset_n_i && !hr_prev_q;

	// capture on the release edge only; ignored afterwards until next reset
	// the strap word is sampled in the cycle that hard reset is first seen high,
	// while the pull-ups are still on, so a pad with no resistor reads its default.
	// hr_prev_q resets low, so leaving the async reset with hard reset already high
	// counts as a release and the straps are taken then.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hr_prev_q <= 1'b0;
			cap_q <= '1;
			pll_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			hr_prev_q <= hard_reset_n_i;
			if (!hard_reset_n_i)
				done_q <= 1'b0; // back to input role
			else if (release_w)
			begin
				cap_q <= cfg_pin_i;
				pll_q <= pll_pin_i;
			end
			// switch to output only when the pull-up hold has run out
			if (hard_reset_n_i && !done_q && hold_q == 8'h00 && !release_w)
				done_q <= 1'b1;
		end
	end

	// pull-up hold counter: loaded at release, counts the extra clocks
	// it is held loaded for the whole of hard reset so a short pulse on the pin
	// cannot leave the counter part-way through; done waits for it to reach zero.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			hold_q <= 8'h00;
		else if (!hard_reset_n_i || release_w)
			hold_q <= 8'(PULLUP_HOLD_CYC);
		else if (hold_q != 8'h00)
			hold_q <= hold_q - 8'h01;
	end

	// pin control: receiver and pull-up share one enable so both drop together
	// the driver enable also needs hard reset high: a new hard reset turns the
	// driver off at once, a cycle before done_q itself is cleared.
	// limitation: cfg_pin_o always follows func_out_i; only the enable gates it.
	always_comb
	begin
		cfg_rx_en_o = {NUM_CFG{!done_q}};
		cfg_pullup_en_o = {NUM_CFG{!done_q}};
		cfg_pin_oe_o = {NUM_CFG{done_q && hard_reset_n_i}};
		cfg_pin_o = func_out_i;
	end
	// pll ratio straps have no pull-up control at all: board must drive them

	// decode: high is default (serial enabled, arbiter enabled)
	// a high level is the default so that a board with no resistor on a strap
	// gets the normal setting from the on-chip pull-up alone.
	// the serial block power-down from the strap exists only on the early revision.
	strap_cfg_t cfg;
	assign cfg.srds_block_pd = EARLY_REV && !cap_q[SRDS_EN_BIT];
	assign cfg.pci_arb_en = cap_q[PCI_ARB_BIT];

	// software registers
	// both registers take whole 32-bit words; there are no byte strobes on this bus.
	// a write lands at the edge that ends the access phase.
	// the strap status word is read-only and ignores writes.
	logic [31:0] lane_ctrl_q;
	logic [31:0] dev_dis_q;
	logic wr_en; // access phase write
	assign wr_en = req.psel && req.penable && req.pwrite;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lane_ctrl_q <= LANE_CTRL_RST;
			dev_dis_q <= DEV_DIS_RST;
		end
		else if (wr_en)
		begin
			if (req.paddr == SERIAL_LANE_CONTROL_1_OFF)
				lane_ctrl_q <= req.pwdata;
			else if (req.paddr == DEVICE_DISABLE_OFF)
				dev_dis_q <= req.pwdata;
		end
	end

	// read mux and unmapped error, zero-wait answers
	// read data is chosen in the setup cycle and registered, so it stands through
	// the access phase; an unmapped offset reads as zero and raises pslverr.
	logic mapped;
	logic [31:0] rd_d;
	always_comb
	begin
		mapped = 1'b1;
		rd_d = 32'h0000_0000;
		if (req.paddr == SERIAL_LANE_CONTROL_1_OFF)
			rd_d = lane_ctrl_q;
		else if (req.paddr == DEVICE_DISABLE_OFF)
			rd_d = dev_dis_q;
		else if (req.paddr == STRAP_STATUS_OFF)
		begin
			rd_d[NUM_CFG-1:0] = cap_q;
			rd_d[SRDS_PD_BIT] = cfg.srds_block_pd;
			rd_d[CAP_DONE_BIT] = done_q;
			rd_d[PLL_LSB +: NUM_PLL] = pll_q;
		end
		else
			mapped = 1'b0;
	end
	// every access completes in one cycle: no register here needs extra time
	assign pready_o = 1'b1;
	assign pslverr_o = req.psel && req.penable && !mapped;
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			prdata_o <= 32'h0000_0000;
		else if (req.psel && !req.penable && !req.pwrite)
			prdata_o <= rd_d; // setup-phase fetch, held through access
	end

	// applied settings, registered
	// all settings go through a flop so the pads see clean levels; the cost is a
	// cycle of delay after a register write or a strap decode change.
	// only the serial block power-down and the pci outputs wait for done_q, so those stay quiet during the pull-up hold.
	// the lane gate is not tied to done_q: it follows the lane register and the strapped serial block power-down.
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serial_lane_rx_o <= '0;
			serial_block_pd_o <= 1'b0;
			pci_ad_oe_o <= 1'b0;
			pci_block_en_o <= 1'b0;
			machine_check_o <= 1'b0;
		end
		else
		begin
			// powered-down lane holds receiver output at zero
			serial_lane_rx_o <= serial_lane_rx_i &
				~lane_ctrl_q[LANE_PD_LSB +: NUM_LANES] &
				{NUM_LANES{!cfg.srds_block_pd}};
			serial_block_pd_o <= done_q && cfg.srds_block_pd;
			pci_ad_oe_o <= done_q && cfg.pci_arb_en &&
				!dev_dis_q[DIS_PCI_BIT];
			pci_block_en_o <= done_q && !dev_dis_q[DIS_PCI_BIT];
			machine_check_o <= !soft_reset_n_i; // no reset effect
		end
	end

	// debug reset merging and tap reset are board/tap matters
	// the tap controller sits outside this block; it is reset through its own pins.

	// checks: every property is sampled on clk_i and off while the synchronised reset is low
	a_cap_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		hr_prev_q && $past(hr_prev_q) |-> $stable(cap_q))
		else $error("strap capture changed outside release");
	a_cap_value: assert property (@(posedge clk_i) disable iff (!rst_n)
		release_w |=> cap_q == $past(cfg_pin_i))
		else $error("strap not latched on release");
	a_drv_off: assert property (@(posedge clk_i) disable iff (!rst_n)
		!hard_reset_n_i |-> cfg_pin_oe_o == '0)
		else $error("driver on during hard reset");
	a_pull_rx: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg_pullup_en_o == cfg_rx_en_o)
		else $error("pull-up and receiver disagree");
	a_pull_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		release_w ##1 hard_reset_n_i[*2] |-> cfg_pullup_en_o == '1)
		else $error("pull-up dropped too early");
	a_out_back: assert property (@(posedge clk_i) disable iff (!rst_n)
		release_w ##1 hard_reset_n_i[*8] |-> cfg_pin_oe_o == '1)
		else $error("output role not restored");
	a_mc_soft: assert property (@(posedge clk_i) disable iff (!rst_n)
		!soft_reset_n_i |=> machine_check_o)
		else $error("soft reset gave no machine check");
	a_pci_in: assert property (@(posedge clk_i) disable iff (!rst_n)
		!cfg.pci_arb_en |=> !pci_ad_oe_o)
		else $error("pci pads driven with arbiter off");
	a_lane_pd: assert property (@(posedge clk_i) disable iff (!rst_n)
		lane_ctrl_q[0] |=> !serial_lane_rx_o[0])
		else $error("powered-down lane not held");
	c_release: cover property (@(posedge clk_i) disable iff (!rst_n) release_w);
	c_pci_on: cover property (@(posedge clk_i) disable iff (!rst_n) pci_ad_oe_o);
	c_srds_pd: cover property (@(posedge clk_i) disable iff (!rst_n) serial_block_pd_o);

	// pin roles during hard reset
	a_rx_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
		!hard_reset_n_i |=> cfg_rx_en_o == '1)
		else $error("receiver off during hard reset");

	// pull-ups come back with every new hard reset
	a_pull_reset: assert property (@(posedge clk_i) disable iff (!rst_n)
		!hard_reset_n_i |=> cfg_pullup_en_o == '1)
		else $error("pull-up off during hard reset");

	// the hold countdown never runs above its load value
	a_hold_range: assert property (@(posedge clk_i) disable iff (!rst_n)
		hold_q <= 8'(PULLUP_HOLD_CYC))
		else $error("pull-up hold count out of range");

	// a driven pad never fights its own pull-up
	a_oe_pull: assert property (@(posedge clk_i) disable iff (!rst_n)
		(cfg_pin_oe_o & cfg_pullup_en_o) == '0)
		else $error("pad driven with pull-up on");

	// once done, the functional role stays until the next hard reset
	a_done_stay: assert property (@(posedge clk_i) disable iff (!rst_n)
		done_q && hard_reset_n_i |=> done_q)
		else $error("functional role lost without hard reset");

	// pll straps are held as firmly as the other straps
	a_pll_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
		hr_prev_q && $past(hr_prev_q) |-> $stable(pll_q))
		else $error("pll strap capture changed outside release");

	// register writes land at the access edge
	a_lane_write: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_en && req.paddr == SERIAL_LANE_CONTROL_1_OFF |=>
		lane_ctrl_q == $past(req.pwdata))
		else $error("lane control write lost");
	// the disable register takes its word the same way
	a_dis_write: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_en && req.paddr == DEVICE_DISABLE_OFF |=>
		dev_dis_q == $past(req.pwdata))
		else $error("device disable write lost");

	// the status word cannot be written
	a_status_ro: assert property (@(posedge clk_i) disable iff (!rst_n)
		wr_en && req.paddr == STRAP_STATUS_OFF |=> $stable(lane_ctrl_q) && $stable(dev_dis_q))
		else $error("status write changed a register");

	// applied settings follow their sources one cycle later
	a_block_pd: assert property (@(posedge clk_i) disable iff (!rst_n)
		done_q && cfg.srds_block_pd |=> serial_block_pd_o)
		else $error("serial block not powered down");
	// a downed block holds every lane receiver output
	a_block_lanes: assert property (@(posedge clk_i) disable iff (!rst_n)
		cfg.srds_block_pd |=> serial_lane_rx_o == '0)
		else $error("lanes active in downed block");
	// arbiter strapped on drives the pads once the capture is done
	a_pci_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
		done_q && cfg.pci_arb_en && !dev_dis_q[DIS_PCI_BIT] |=> pci_ad_oe_o)
		else $error("pci pads not driven with arbiter on");
	// a disabled pci block neither runs nor drives
	a_pci_off: assert property (@(posedge clk_i) disable iff (!rst_n)
		dev_dis_q[DIS_PCI_BIT] |=> !pci_block_en_o && !pci_ad_oe_o)
		else $error("disabled pci block still active");
	// machine check follows soft reset back down
	a_mc_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
		soft_reset_n_i |=> !machine_check_o)
		else $error("machine check without soft reset");

	// further scenarios worth seeing
	c_lane_down: cover property (@(posedge clk_i) disable iff (!rst_n)
		lane_ctrl_q[0] && serial_lane_rx_i[0]);
	c_pci_off: cover property (@(posedge clk_i) disable iff (!rst_n)
		done_q && dev_dis_q[DIS_PCI_BIT]);
endmodule

// *** board_straps.sv ***
// board side model: strap resistors on the shared pins and merged reset sources
// assumes the device drives a pin only while its output enable is high
module board_straps
(
	input wire logic clk_i,
	input wire logic [strap_pkg::NUM_CFG-1:0] pulldown_i, // resistor to ground fitted
	input wire logic [strap_pkg::NUM_CFG-1:0] pullup_en_i,
	input wire logic [strap_pkg::NUM_CFG-1:0] oe_i,
	input wire logic [strap_pkg::NUM_CFG-1:0] dev_out_i,
	input wire logic board_rst_n_i,
	input wire logic dbg_rst_n_i,
	output logic [strap_pkg::NUM_CFG-1:0] pin_o,
	output logic hard_reset_n_o
);
	import strap_pkg::*;
	logic [NUM_CFG-1:0] last_q; // level seen before a pin went undriven
	// debug port and board sources merged by a plain and gate
	assign hard_reset_n_o = board_rst_n_i & dbg_rst_n_i;
	// wire level: driver first, then resistors; a float drifts to the inverse
	always_comb
	begin
		for (int i = 0; i < NUM_CFG; i++)
		begin
			pin_o[i] = oe_i[i] ? dev_out_i[i] : pulldown_i[i] ? 1'b0 :
				pullup_en_i[i] ? 1'b1 : ~last_q[i];
		end
	end
	// remember the last level for the floating case
	always_ff @(posedge clk_i) last_q <= pin_o;
endmodule

// *** testbench.sv ***
// self-checking bench for the strap capture block, three hard reset rounds
// assumes the block answers apb with zero wait states or more
module testbench;
	import strap_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
		$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
	logic clk_i = 0, arst_n_i = 0, soft_reset_n_i = 1, brd_n = 1, dbg_n = 1;
	logic psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, hrst_n;
	logic [19:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, r;
	logic [7:0] strap = '1, func_out_i = '0, lane_rx = '0, pd, pin, oe, rx_en, pu, pin_o, lrx;
	logic [3:0] pll = '0;
	logic bpd, arb, pci_en, mck, e;
	int n_errors = 0, checks_done = 0, n;
	always #50 clk_i = ~clk_i;
	board_straps board_straps_inst (.clk_i(clk_i), .pulldown_i(~strap), .pullup_en_i(pu),
		.oe_i(oe), .dev_out_i(pin_o), .board_rst_n_i(brd_n), .dbg_rst_n_i(dbg_n),
		.pin_o(pin), .hard_reset_n_o(hrst_n));
	reset_strap_capture reset_strap_capture_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.hard_reset_n_i(hrst_n), .soft_reset_n_i(soft_reset_n_i), .cfg_pin_i(pin),
		.func_out_i(func_out_i), .pll_pin_i(pll), .serial_lane_rx_i(lane_rx),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .cfg_pin_o(pin_o), .cfg_pin_oe_o(oe), .cfg_rx_en_o(rx_en),
		.cfg_pullup_en_o(pu), .serial_lane_rx_o(lrx), .serial_block_pd_o(bpd),
		.pci_ad_oe_o(arb), .pci_block_en_o(pci_en), .machine_check_o(mck));
	// one apb transfer; the leading edge keeps two transfers from colliding
	task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 100);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
	endtask
	// received lanes: a downed lane or block holds zero
	function automatic logic [7:0] exp_lane(logic [7:0] x, logic [7:0] p, logic b);
		return b ? 8'h00 : x & ~p;
	endfunction
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog sized well past three rounds
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		finish_test();
	end
	initial
	begin
		void'($urandom(32'hdadc8945));
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1;
		repeat (3) @(posedge clk_i);
		for (int it = 0; it < 3; it++)
		begin
			// corner straps first: all default, all non-default, then random
			strap <= (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
			pll <= 4'($urandom);
			brd_n <= (it == 1);
			dbg_n <= (it != 1);
			repeat (4) @(posedge clk_i);
			`CHK(oe, 8'h00)
			`CHK(pu & rx_en, 8'hff)
			brd_n <= 1;
			dbg_n <= 1;
			n = 0;
			do
			begin
				@(negedge clk_i);
				n++;
			end
			while (pu === 8'hff && n < 50);
			`CHK(n > PULLUP_HOLD_CYC, 1'b1)
			repeat (3) @(posedge clk_i);
			`CHK({oe, rx_en, pu}, 24'hff0000)
			func_out_i <= 8'($urandom);
			apb(0, STRAP_STATUS_OFF, 0);
			`CHK(pin_o, func_out_i)
			`CHK({r[19:16], r[9], r[7:0]}, {pll, 1'b1, strap})
			`CHK({bpd, arb}, {~strap[SRDS_EN_BIT], strap[PCI_ARB_BIT]})
			pd = 8'($urandom);
			lane_rx <= 8'($urandom);
			apb(1, SERIAL_LANE_CONTROL_1_OFF, {24'h0, pd});
			apb(0, SERIAL_LANE_CONTROL_1_OFF, 0);
			`CHK(r, {24'h0, pd})
			`CHK(lrx, exp_lane(lane_rx, pd, ~strap[SRDS_EN_BIT]))
			apb(1, DEVICE_DISABLE_OFF, 32'h1);
			repeat (2) @(posedge clk_i);
			`CHK({pci_en, arb}, 2'b00)
			apb(1, DEVICE_DISABLE_OFF, 32'h0);
			repeat (2) @(posedge clk_i);
			`CHK(pci_en, 1'b1)
			apb(0, 20'h00010, 0);
			`CHK({e, r}, {1'b1, 32'h0})
			soft_reset_n_i <= 0;
			repeat (2) @(posedge clk_i);
			`CHK({mck, oe}, {1'b1, 8'hff})
			soft_reset_n_i <= 1;
			$display("round %0d done", it);
		end
		finish_test();
	end
endmodule
